/* File: rtl/ppm_pkg.sv */
package ppm_pkg;

  // ----------------------------------------------------------------
  // Parameter addresses on the fieldbus
  // ----------------------------------------------------------------
  localparam logic [15:0] PPM_ADDR_GOAL_POS = 16'h1b1c;
  localparam logic [15:0] PPM_ADDR_GOAL_SPD = 16'h1b1e;
  localparam logic [15:0] PPM_ADDR_REL_OPT = 16'h1b30;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] PPM_RST_GOAL_POS = 32'h0000_0000;
  localparam logic [31:0] PPM_RST_GOAL_SPD = 32'h0000_003c;
  localparam logic [31:0] PPM_MIN_GOAL_SPD = 32'h0000_0001;
  localparam logic [15:0] PPM_RST_REL_OPT = 16'h0000;
  localparam logic [15:0] PPM_OPT_PREV_TARGET = 16'h0000;
  localparam logic [15:0] PPM_OPT_RESERVED = 16'h0001;
  localparam logic [15:0] PPM_OPT_ACTUAL_POS = 16'h0002;
  localparam logic [15:0] PPM_RST_WORD = 16'h0000;

  // Mode code for this positioning mode; value is arbitrary
  localparam logic [15:0] PPM_MODE_PROFILE_POS = 16'h0001;

  // ----------------------------------------------------------------
  // Control and status word bit positions
  // ----------------------------------------------------------------
  localparam int PPM_CW_NEW_SETPOINT = 4;
  localparam int PPM_CW_CHANGE_NOW = 5;
  localparam int PPM_CW_RELATIVE = 6;
  localparam int PPM_SW_TARGET_REACHED = 10;
  localparam int PPM_SW_SETPOINT_ACK = 12;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
  } ppm_move_s;

  typedef struct packed {
    logic [31:0] actual_pos;
    logic [31:0] zero_point;
    logic at_target;
    logic standstill;
    logic halt;
    logic quick_stop;
    logic fault;
  } ppm_fb_s;

  typedef enum logic [1:0] {
    PPM_IDLE,
    PPM_MOVING,
    PPM_STOPPING
  } ppm_state_e;

endpackage

/* File: rtl/ppm_profile_position.sv */
`timescale 1ns/1ps

// Behaviour
// - Mode-select write activates positioning mode
// - Bit4 rising edge starts move to target
// - Bit5 clear: new targets wait for target
// - Bit5 set: new targets replace move now
// - Target set: position, speed, accel, decel
// - Bit6 selects absolute or relative move
// - Status bit10 shows target reached
// - Under halt bit10 shows standstill
// - Status bit12 shows setpoint accepted
// - Mode ends on any mode-select write of another code
// - Absolute move referenced to homing zero
// - Option picks relative reference, next move
// - Speed min 1, clamped to ceilings
// - Speed change applies at next setpoint
// - Target position write effective immediately; here it is used only from the next setpoint edge
// - Relative base: previous target or actual
module ppm_profile_position (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Parameter access port
  input wire logic par_wr_i,
  input wire logic par_rd_i,
  input wire logic [15:0] par_addr_i,
  input wire logic [31:0] par_wdata_i,
  output logic [31:0] par_rdata_o,
  output logic par_rvalid_o,
  output logic par_err_o,
  // Mode select and control word
  input wire logic opmode_wr_i,
  input wire logic [15:0] operating_mode_select_i,
  input wire logic [15:0] motion_control_word_i,
  output logic [15:0] motion_status_word_o,
  output logic mode_active_o,
  // Profile values not held in parameters
  input wire logic [31:0] accel_i,
  input wire logic [31:0] decel_i,
  input wire logic [31:0] ctrl_speed_ceiling_i,
  input wire logic [31:0] ramp_speed_ceiling_i,
  // Motion feedback
  input ppm_pkg::ppm_fb_s fb_i,
  // Move command to profile generator
  output ppm_pkg::ppm_move_s move_o,
  output logic move_start_o
);
  import ppm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Smallest of request and both ceilings, never below one
  function automatic logic [31:0] clamp_speed(input logic [31:0] req, input logic [31:0] c1,
                                              input logic [31:0] c2);
    logic [31:0] v;
    v = (c1 < req) ? c1 : req;
    v = (c2 < v) ? c2 : v;
    v = (v < PPM_MIN_GOAL_SPD) ? PPM_MIN_GOAL_SPD : v;
    return v;
  endfunction

  // Destination in absolute counts from the move type and base
  function automatic logic [31:0] calc_dest(input logic rel, input logic [15:0] opt,
                                            input logic [31:0] goal, input logic [31:0] prev,
                                            input ppm_fb_s fb);
    logic [31:0] base;
    base = rel ? ((opt == PPM_OPT_ACTUAL_POS) ? fb.actual_pos : prev) : fb.zero_point;
    return 32'(base + goal);
  endfunction

  // ----------------------------------------------------------------
  // Parameter storage
  // ----------------------------------------------------------------
  logic [31:0] goal_position_ff;
  logic [31:0] goal_speed_ff;
  logic [15:0] relative_reference_option_ff;
  logic wr_pos;
  logic wr_spd;
  logic wr_opt;
  logic spd_ok;
  logic opt_ok;

  assign wr_pos = par_wr_i && (par_addr_i == PPM_ADDR_GOAL_POS);
  assign wr_spd = par_wr_i && (par_addr_i == PPM_ADDR_GOAL_SPD);
  assign wr_opt = par_wr_i && (par_addr_i == PPM_ADDR_REL_OPT);
  assign spd_ok = (par_wdata_i >= PPM_MIN_GOAL_SPD);
  assign opt_ok = (par_wdata_i[15:0] <= PPM_OPT_ACTUAL_POS) && (par_wdata_i[31:16] == 16'h0000);

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      goal_position_ff <= PPM_RST_GOAL_POS;
    end
    else if (wr_pos)
    begin
      goal_position_ff <= par_wdata_i;
    end
  end

  // writes below the minimum are refused
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      goal_speed_ff <= PPM_RST_GOAL_SPD;
    end
    else if (wr_spd && spd_ok)
    begin
      goal_speed_ff <= par_wdata_i;
    end
  end

  // Options above two are refused; reserved value one is kept
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      relative_reference_option_ff <= PPM_RST_REL_OPT;
    end
    else if (wr_opt && opt_ok)
    begin
      relative_reference_option_ff <= par_wdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  logic [31:0] nxt_rdata;
  logic addr_hit;

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    addr_hit = 1'b1;
    unique case (par_addr_i)
      PPM_ADDR_GOAL_POS: nxt_rdata = goal_position_ff;
      PPM_ADDR_GOAL_SPD: nxt_rdata = goal_speed_ff;
      PPM_ADDR_REL_OPT: nxt_rdata = {16'h0000, relative_reference_option_ff};
      default: addr_hit = 1'b0;
    endcase
  end

  // Answer one cycle after the strobe; error on bad address or value
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      par_rdata_o <= 32'h0000_0000;
      par_rvalid_o <= 1'b0;
      par_err_o <= 1'b0;
    end
    else
    begin
      par_rvalid_o <= par_rd_i;
      par_rdata_o <= par_rd_i ? nxt_rdata : 32'h0000_0000;
      par_err_o <= ((par_rd_i || par_wr_i) && !addr_hit) || (wr_spd && !spd_ok) || (wr_opt && !opt_ok);
    end
  end

  // ----------------------------------------------------------------
  // Mode activation
  // ----------------------------------------------------------------
  logic mode_active_ff;

  // the mode-select write alone switches the mode
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_active_ff <= 1'b0;
    end
    else if (opmode_wr_i)
    begin
      mode_active_ff <= (operating_mode_select_i == PPM_MODE_PROFILE_POS);
    end
  end

  // ----------------------------------------------------------------
  // Setpoint edge detection
  // ----------------------------------------------------------------
  logic cw_bit4_ff;
  logic setpoint_edge;

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cw_bit4_ff <= 1'b0;
    end
    else
    begin
      cw_bit4_ff <= motion_control_word_i[PPM_CW_NEW_SETPOINT];
    end
  end

  // zero to one on bit 4 is a new setpoint
  // only counted while the mode is active
  assign setpoint_edge = mode_active_ff && motion_control_word_i[PPM_CW_NEW_SETPOINT] && !cw_bit4_ff;

  // ----------------------------------------------------------------
  // Setpoint assembly
  // ----------------------------------------------------------------
  ppm_move_s new_move;
  logic [31:0] prev_target_ff;

  // the full target set travels together
  always_comb
  begin
    // bit 6 picks absolute or relative
    // absolute goal sits on homing zero
    // option sampled now, so it counts from this move
    new_move.pos = calc_dest(motion_control_word_i[PPM_CW_RELATIVE], relative_reference_option_ff,
                             goal_position_ff, prev_target_ff, fb_i);
    // speed sampled when the setpoint edge is taken, also for a queued move
    new_move.speed = clamp_speed(goal_speed_ff, ctrl_speed_ceiling_i, ramp_speed_ceiling_i);
    new_move.accel = accel_i;
    new_move.decel = decel_i;
  end

  // ----------------------------------------------------------------
  // Move sequencing
  // ----------------------------------------------------------------
  ppm_state_e state_ff;
  ppm_move_s pending_ff;
  logic pending_vld_ff;
  logic stop_event;
  logic issue_now;
  logic issue_pending;
  logic arrived;

  // Halt, quick stop and faults end a move at standstill
  assign stop_event = fb_i.halt || fb_i.quick_stop || fb_i.fault;
  // Generator answers a start a cycle late, so stale arrival is ignored then
  assign arrived = fb_i.at_target && fb_i.standstill && !move_start_o;
  // bit 5 set replaces the running move
  assign issue_now = setpoint_edge && !stop_event &&
                     ((state_ff != PPM_MOVING) || motion_control_word_i[PPM_CW_CHANGE_NOW]);
  // queued targets run once the current one is reached
  assign issue_pending = (state_ff == PPM_MOVING) && pending_vld_ff && arrived && !stop_event;

  // Queued setpoint for the deferred case; a later edge overwrites it
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pending_ff <= '0;
      pending_vld_ff <= 1'b0;
    end
    else if (setpoint_edge && !issue_now && !stop_event)
    begin
      pending_ff <= new_move;
      pending_vld_ff <= 1'b1;
    end
    else if (issue_pending || issue_now || stop_event || !mode_active_ff)
      pending_vld_ff <= 1'b0;
  end

  // Command outputs come from flops; start is a one-cycle pulse
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      move_o <= '0;
      move_start_o <= 1'b0;
      prev_target_ff <= 32'h0000_0000;
    end
    else
    begin
      move_start_o <= issue_now || issue_pending;
      if (issue_now)
      begin
        move_o <= new_move;
        prev_target_ff <= new_move.pos;
      end
      else if (issue_pending)
      begin
        move_o <= pending_ff;
        prev_target_ff <= pending_ff.pos;
      end
    end
  end

  // leave motion only at standstill after an ending event
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= PPM_IDLE;
    end
    else
    begin
      unique case (state_ff)
        PPM_IDLE:
        begin
          if (issue_now)
            state_ff <= PPM_MOVING;
        end
        PPM_MOVING:
        begin
          if (stop_event)
            state_ff <= fb_i.standstill ? PPM_IDLE : PPM_STOPPING;
          else if (arrived && !pending_vld_ff && !issue_now)
            state_ff <= PPM_IDLE;
        end
        PPM_STOPPING:
        begin
          if (fb_i.standstill)
            state_ff <= PPM_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic ack_ff;
  logic nxt_reached;

  // set on acceptance, cleared when bit 4 returns low; set wins
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
    end
    else if (setpoint_edge && !stop_event)
      ack_ff <= 1'b1;
    else if (!motion_control_word_i[PPM_CW_NEW_SETPOINT] || !mode_active_ff)
      ack_ff <= 1'b0;
  end

  // under halt it mirrors standstill instead
  assign nxt_reached = fb_i.halt ? fb_i.standstill : (state_ff == PPM_IDLE) && fb_i.at_target;

  // Other bits belong to the common state machine and read zero here
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      motion_status_word_o <= PPM_RST_WORD;
      mode_active_o <= 1'b0;
    end
    else
    begin
      motion_status_word_o <= PPM_RST_WORD;
      motion_status_word_o[PPM_SW_TARGET_REACHED] <= mode_active_ff && nxt_reached;
      motion_status_word_o[PPM_SW_SETPOINT_ACK] <= ack_ff;
      mode_active_o <= mode_active_ff;
    end
  end

endmodule // ppm_profile_position

/* File: verif/ppm_motion_model.sv */
`timescale 1ns/1ps
module ppm_motion_model
  import ppm_pkg::*;
#(
  parameter int TRAVEL = 20,
  parameter logic [31:0] ZERO = 32'h0000_1000
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Command side
  input wire logic start_i,
  input wire ppm_move_s move_i,
  input wire logic halt_i,
  // Feedback
  output ppm_fb_s fb_o
);
  int cnt_ff;

  // Fixed travel time; a halted move ends at standstill without arrival
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff <= 0;
      fb_o <= {32'h0000_0000, ZERO, 5'b11000};
    end
    else
    begin
      fb_o.halt <= halt_i;
      if (start_i)
      begin
        cnt_ff <= TRAVEL;
        fb_o.at_target <= 1'b0;
        fb_o.standstill <= 1'b0;
      end
      else if (cnt_ff == 1)
      begin
        cnt_ff <= 0;
        fb_o.standstill <= 1'b1;
        fb_o.at_target <= !halt_i;
        if (!halt_i)
          fb_o.actual_pos <= move_i.pos;
      end
      else if (cnt_ff > 1)
        cnt_ff <= cnt_ff - 1;
    end
  end
endmodule // ppm_motion_model

/* File: verif/ppm_profile_position_monitor.sv */
`timescale 1ns/1ps
module ppm_profile_position_monitor
  import ppm_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Parameter port
  input wire logic par_wr_i,
  input wire logic [15:0] par_addr_i,
  input wire logic [31:0] par_wdata_i,
  input wire logic par_err_o,
  // Mode and words
  input wire logic opmode_wr_i,
  input wire logic [15:0] operating_mode_select_i,
  input wire logic [15:0] motion_control_word_i,
  input wire logic [15:0] motion_status_word_o,
  input wire logic mode_active_o,
  // Motion side
  input ppm_fb_s fb_i,
  input ppm_move_s move_o,
  input wire logic move_start_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  // Mode flag lags the internal one, so no mode write may sit one edge back
  sequence s_take;
    $rose(motion_control_word_i[4]) && mode_active_o && !opmode_wr_i && !$past(opmode_wr_i)
      && !fb_i.halt && !fb_i.quick_stop && !fb_i.fault;
  endsequence
  property p_mode;
    (opmode_wr_i && (operating_mode_select_i == PPM_MODE_PROFILE_POS)) ##1 !opmode_wr_i |=> mode_active_o;
  endproperty
  a_mode: assert property (p_mode) else $error("mode not active after select");
  property p_start;
    s_take ##0 motion_control_word_i[5] |=> move_start_o;
  endproperty
  a_start: assert property (p_start) else $error("immediate setpoint not started");
  property p_ack;
    s_take |=> ##1 motion_status_word_o[12];
  endproperty
  a_ack: assert property (p_ack) else $error("setpoint not acknowledged");
  property p_ign;
    $rose(motion_control_word_i[4]) && !mode_active_o && !opmode_wr_i && !$past(opmode_wr_i) |=> !move_start_o;
  endproperty
  a_ign: assert property (p_ign) else $error("start outside mode");
  property p_clr;
    !motion_control_word_i[4] [*3] |-> !motion_status_word_o[12];
  endproperty
  a_clr: assert property (p_clr) else $error("ack stuck high");
  property p_hold;
    !move_start_o |-> $stable(move_o);
  endproperty
  a_hold: assert property (p_hold) else $error("move changed without start");
  property p_b10;
    !fb_i.at_target && !fb_i.halt |=> !motion_status_word_o[10];
  endproperty
  a_b10: assert property (p_b10) else $error("target flag without arrival");
  property p_espd;
    par_wr_i && par_addr_i == PPM_ADDR_GOAL_SPD && par_wdata_i == 32'h0000_0000 |=> par_err_o;
  endproperty
  a_espd: assert property (p_espd) else $error("zero speed accepted");

  // Main scenarios reached
  c_start: cover property (move_start_o);
  c_err: cover property (par_err_o);
  c_reach: cover property (motion_status_word_o[10]);
endmodule // ppm_profile_position_monitor

bind ppm_profile_position ppm_profile_position_monitor mon (.mclk_i, .rst_i, .par_wr_i, .par_addr_i,
  .par_wdata_i, .par_err_o, .opmode_wr_i, .operating_mode_select_i, .motion_control_word_i,
  .motion_status_word_o, .mode_active_o, .fb_i, .move_o, .move_start_o);

/* File: verif/ppm_profile_position_tb.sv */
`timescale 1ns/1ps
module ppm_profile_position_tb;
  import ppm_pkg::*;
  logic mclk_i = 0;
  logic rst_i = 1;
  logic par_wr = 0;
  logic par_rd = 0;
  logic opwr = 0;
  logic halt = 0;
  logic [15:0] addr = 0;
  logic [15:0] cw = 0;
  logic [15:0] opsel = 0;
  logic [31:0] wdata = 0;
  logic [31:0] ceil = 32'h0000_ffff;
  logic [31:0] rdata;
  logic [15:0] sw;
  logic rvalid, err, act, st;
  ppm_fb_s fb;
  ppm_move_s mv;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;

  always #2.5 mclk_i = ~mclk_i;

  ppm_profile_position uut (.mclk_i(mclk_i), .rst_i(rst_i), .par_wr_i(par_wr), .par_rd_i(par_rd),
    .par_addr_i(addr), .par_wdata_i(wdata), .par_rdata_o(rdata), .par_rvalid_o(rvalid), .par_err_o(err),
    .opmode_wr_i(opwr), .operating_mode_select_i(opsel), .motion_control_word_i(cw),
    .motion_status_word_o(sw), .mode_active_o(act), .accel_i(32'h0000_0005), .decel_i(32'h0000_0006),
    .ctrl_speed_ceiling_i(ceil), .ramp_speed_ceiling_i(32'h0000_ffff), .fb_i(fb), .move_o(mv),
    .move_start_o(st));
  ppm_motion_model plant (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(st), .move_i(mv), .halt_i(halt),
    .fb_o(fb));

  task test_done;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One parameter access; error flag and read data one cycle later
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d, input logic e, input logic [31:0] r);
    @(negedge mclk_i);
    par_wr = w;
    par_rd = !w;
    addr = a;
    wdata = d;
    @(negedge mclk_i);
    par_wr = 0;
    par_rd = 0;
    chk(err, e);
    chk(rvalid, !w);
    if (!w)
      chk(rdata, r);
  endtask

  task wst(input int lim, output int n);
    n = 0;
    while (st !== 1'b1 && n < lim)
    begin
      @(negedge mclk_i);
      n++;
    end
  endtask

  // Raise the new-setpoint bit with given change-now and relative bits
  task sp(input logic [1:0] b65, input int lim, output int n);
    @(negedge mclk_i);
    cw = {9'h000, b65, 1'b1, 4'h0};
    wst(lim, n);
  endtask

  task low;
    @(negedge mclk_i);
    cw[4] = 1'b0;
  endtask

  task arrive;
    int n;
    n = 0;
    while (sw[10] !== 1'b1 && n < 40)
    begin
      @(negedge mclk_i);
      n++;
    end
    chk(sw[10], 1);
  endtask

  // Hang guard, far above the roughly 150 cycles needed
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      mismatches++;
      test_done;
    end
  end

  initial
  begin
    int n;
    repeat (12) @(negedge mclk_i);
    rst_i = 0;
    acc(0, PPM_ADDR_GOAL_POS, 0, 0, PPM_RST_GOAL_POS);
    acc(0, PPM_ADDR_GOAL_SPD, 0, 0, PPM_RST_GOAL_SPD);
    acc(0, PPM_ADDR_REL_OPT, 0, 0, 32'(PPM_RST_REL_OPT));
    acc(0, 16'h1b00, 0, 1, 0);
    acc(1, PPM_ADDR_GOAL_SPD, 0, 1, 0);
    acc(0, PPM_ADDR_GOAL_SPD, 0, 0, PPM_RST_GOAL_SPD);
    acc(1, PPM_ADDR_REL_OPT, 32'h0000_0003, 1, 0);
    acc(1, PPM_ADDR_GOAL_POS, 32'h0000_0100, 0, 0);
    acc(0, PPM_ADDR_GOAL_POS, 0, 0, 32'h0000_0100);
    // Start edge before the mode is selected
    sp(2'b00, 6, n);
    chk(32'(n), 6);
    low;
    @(negedge mclk_i);
    opwr = 1;
    opsel = PPM_MODE_PROFILE_POS;
    @(negedge mclk_i);
    opwr = 0;
    @(negedge mclk_i);
    chk(act, 1);
    // Absolute move from the homed zero
    sp(2'b00, 4, n);
    chk(mv.pos, 32'h0000_1100);
    chk(mv.speed, 32'h0000_003c);
    repeat (2) @(negedge mclk_i);
    chk(sw[12], 1);
    low;
    repeat (3) @(negedge mclk_i);
    chk(sw[12], 0);
    arrive;
    // Relative move, then a deferred one while moving
    acc(1, PPM_ADDR_GOAL_POS, 32'h0000_0200, 0, 0);
    sp(2'b10, 4, n);
    chk(mv.pos, 32'h0000_1300);
    low;
    acc(1, PPM_ADDR_GOAL_POS, 32'h0000_0050, 0, 0);
    acc(1, PPM_ADDR_GOAL_SPD, 32'h0000_0020, 0, 0);
    sp(2'b10, 6, n);
    chk(32'(n), 6);
    chk(mv.speed, 32'h0000_003c);
    low;
    wst(40, n);
    chk(mv.pos, 32'h0000_1350);
    chk(mv.speed, 32'h0000_0020);
    chk(mv.accel, 32'h0000_0005);
    chk(mv.decel, 32'h0000_0006);
    arrive;
    // Actual-position reference, clamp, immediate replacement
    acc(1, PPM_ADDR_REL_OPT, 32'h0000_0002, 0, 0);
    ceil = 32'h0000_0018;
    acc(1, PPM_ADDR_GOAL_POS, 32'h0000_0010, 0, 0);
    sp(2'b11, 4, n);
    chk(mv.pos, 32'h0000_1360);
    chk(mv.speed, 32'h0000_0018);
    low;
    acc(1, PPM_ADDR_GOAL_POS, 32'h0000_0020, 0, 0);
    sp(2'b11, 4, n);
    chk(st, 1);
    chk(mv.pos, 32'h0000_1370);
    low;
    // Halt in mid-move
    halt = 1;
    repeat (4) @(negedge mclk_i);
    chk(sw[10], 0);
    arrive;
    halt = 0;
    test_done;
  end
endmodule // ppm_profile_position_tb
